// ===== pkg/pio_pkg.sv
// Notes on behaviour
// - rear-end input rise starts move to rear
// - front-end input rise starts move to front
// - mid-A input rise starts move to point A
// - mid-B input rise starts move to point B
// - pause low stops motion, high permits
// - alarm-clear rise clears pending alarm
// - rear done output after rear move finishes
// - front done output after front move finishes
// - mid-A done output after point A reached
// - mid-B done output after point B reached
// - window flag when homed and inside bounds
// - ready needs no estop, power, servo, pause
// - homing done low from reset until homed
// - fault output low while alarm pending
// - estop status low only with relay fitted
// - pause, fault, estop status are active low
// - pattern select 5 enables this assignment
// - pattern 4 lines change meaning by mode
// - input level accepted after 6 ms stable
// - paused move kept, resumes when pause high
// - alarm-clear rise while paused cancels move
package pio_pkg;

  // timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned DEBOUNCE_MS   = 6;
  localparam int unsigned DEBOUNCE_CYC  = (DEBOUNCE_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned STEP_CYC      = 10;

  // widths
  localparam int unsigned AW            = 8;
  localparam int unsigned DW            = 32;
  localparam int unsigned PW            = 16;
  localparam int unsigned NPIN          = 7;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_PATTERN   = 8'h04;
  localparam logic [7:0]  OFS_POINT0    = 8'h08;
  localparam logic [7:0]  OFS_POINT1    = 8'h0c;
  localparam logic [7:0]  OFS_POINT2    = 8'h10;
  localparam logic [7:0]  OFS_POINT3    = 8'h14;
  localparam logic [7:0]  OFS_ZONE_LO   = 8'h18;
  localparam logic [7:0]  OFS_ZONE_HI   = 8'h1c;
  localparam logic [7:0]  OFS_STATUS    = 8'h20;
  localparam logic [7:0]  OFS_POSITION  = 8'h24;

  // control field positions
  localparam int unsigned CTRL_SERVO    = 0;
  localparam int unsigned CTRL_POWER    = 1;
  localparam int unsigned CTRL_RELAY    = 2;
  localparam int unsigned CTRL_HOME     = 3;
  localparam int unsigned CTRL_ALARM    = 4;

  // status field positions
  localparam int unsigned ST_HOMED      = 0;
  localparam int unsigned ST_ALARM      = 1;
  localparam int unsigned ST_MOVING     = 2;
  localparam int unsigned ST_PAUSED     = 3;
  localparam int unsigned ST_READY      = 4;
  localparam int unsigned ST_DONE       = 8;
  localparam int unsigned ST_ZONE       = 12;

  // reset values and the enabling pattern select
  localparam logic [2:0]  PATTERN_RST   = 3'h0;
  localparam logic [2:0]  PATTERN_FOUR  = 3'h5;
  localparam logic [2:0]  CTRL_RST      = 3'h0;
  localparam logic [15:0] POINT_RST     = 16'h0000;
  localparam logic [15:0] ZONE_LO_RST   = 16'h0000;
  localparam logic [15:0] ZONE_HI_RST   = 16'hffff;
  localparam logic [15:0] POS_RST       = 16'h0000;

  // pin index inside the filtered bundle
  localparam int unsigned PIN_REAR      = 0;
  localparam int unsigned PIN_FRONT     = 1;
  localparam int unsigned PIN_MID_A     = 2;
  localparam int unsigned PIN_MID_B     = 3;
  localparam int unsigned PIN_PAUSE_N   = 4;
  localparam int unsigned PIN_CLEAR     = 5;
  localparam int unsigned PIN_ESTOP     = 6;
  localparam logic [6:0]  PIN_IDLE      = 7'h10;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b001,
    S_HOMING = 3'b010,
    S_MOVING = 3'b100
  } axis_state_e;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } reg_req_s;

endpackage

// ===== verilog/pin_filter.sv
`timescale 1ns/1ps
module pin_filter #(
  parameter int unsigned CYCLES  = 60000,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic [2:0]  sync_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        level_nxt;
  wire         agree   = (sync_r[1] == sync_r[2]);
  wire         differs = agree && (sync_r[2] != level);
  wire         expired = (cnt_r == 16'(CYCLES - 1));

  // stability counter restarts on any disagreement
  assign cnt_nxt   = (differs && !expired) ? cnt_r + 16'h0001 : 16'h0000;
  assign level_nxt = (differs && expired) ? sync_r[2] : level;

  // three-stage sampler, then filter state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= {3{RST_VAL}};
      cnt_r  <= 16'h0000;
      level  <= RST_VAL;
    end else begin
      sync_r <= {sync_r[1:0], pin};
      cnt_r  <= cnt_nxt;
      level  <= level_nxt;
    end
  end
endmodule

// ===== verilog/four_point_io.sv
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module four_point_io
  import pio_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = pio_pkg::DEBOUNCE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire pio_pkg::reg_req_s    reg_req,
  output logic [pio_pkg::DW-1:0]    reg_rdata,
  input  wire logic                 rear_end_move_in,
  input  wire logic                 front_end_move_in,
  input  wire logic                 mid_point_a_move_in,
  input  wire logic                 mid_point_b_move_in,
  input  wire logic                 pause_n_in,
  input  wire logic                 alarm_clear_in,
  input  wire logic                 estop_req_in,
  output logic                      rear_end_done_out,
  output logic                      front_end_done_out,
  output logic                      mid_point_a_done_out,
  output logic                      mid_point_b_done_out,
  output logic                      window_flag_out,
  output logic                      axis_ready_out,
  output logic                      homing_done_out,
  output logic                      fault_n_out,
  output logic                      estop_state_n_out
);
  import pio_pkg::*;

  // raw pin bundle and its filtered form
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_prev_r;

  assign pin_raw = {estop_req_in, alarm_clear_in, pause_n_in, mid_point_b_move_in,
                    mid_point_a_move_in, front_end_move_in, rear_end_move_in};

  // one filter per input pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      pin_filter #(
        .CYCLES  (DEBOUNCE_CYCLES),
        .RST_VAL (PIN_IDLE[gi])
      ) u_filter (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (pin_raw[gi]),
        .level (pin_lvl[gi])
      );
    end
  endgenerate

  // software registers
  logic [2:0]      ctrl_r;
  logic [2:0]      pattern_r;
  logic [PW-1:0]   point_r [4];
  logic [PW-1:0]   zone_lo_r;
  logic [PW-1:0]   zone_hi_r;
  logic [DW-1:0]   rdata_nxt;

  // axis state
  axis_state_e     state_r;
  axis_state_e     state_nxt;
  logic [PW-1:0]   pos_r;
  logic [PW-1:0]   pos_nxt;
  logic [1:0]      tgt_idx_r;
  logic [1:0]      tgt_idx_nxt;
  logic            go_after_r;
  logic            go_after_nxt;
  logic            homed_r;
  logic            homed_nxt;
  logic            alarm_r;
  logic            alarm_nxt;
  logic [3:0]      done_r;
  logic [3:0]      done_nxt;
  logic [7:0]      step_cnt_r;

  // register decode
  wire wr_ctrl    = reg_req.wr && (reg_req.addr == OFS_CTRL);
  wire wr_pattern = reg_req.wr && (reg_req.addr == OFS_PATTERN);
  wire wr_zone_lo = reg_req.wr && (reg_req.addr == OFS_ZONE_LO);
  wire wr_zone_hi = reg_req.wr && (reg_req.addr == OFS_ZONE_HI);
  wire home_cmd   = wr_ctrl && reg_req.wdata[CTRL_HOME];
  wire alarm_cmd  = wr_ctrl && reg_req.wdata[CTRL_ALARM];

  // pattern routing: only pattern five drives these functions
  wire pat_on     = (pattern_r == PATTERN_FOUR);

  // filtered levels and edges
  wire [NPIN-1:0] rise   = pin_lvl & ~pin_prev_r;
  wire pause_hi          = pin_lvl[PIN_PAUSE_N];
  wire estop             = pin_lvl[PIN_ESTOP];
  wire servo_on          = ctrl_r[CTRL_SERVO];
  wire power_on          = ctrl_r[CTRL_POWER];
  wire relay_fitted      = ctrl_r[CTRL_RELAY];
  wire drive_ok          = !estop && power_on && servo_on;
  wire ready             = pat_on && drive_ok && pause_hi;
  wire clear_edge        = pat_on && rise[PIN_CLEAR];

  // move request with fixed priority rear, front, mid A, mid B
  wire [3:0] move_rise   = rise[PIN_MID_B:PIN_REAR];
  wire move_req          = pat_on && (move_rise != 4'h0) && !alarm_r && drive_ok;
  wire [1:0] move_idx    = move_rise[0] ? 2'd0 :
                           move_rise[1] ? 2'd1 :
                           move_rise[2] ? 2'd2 :
                           2'd3;

  // stepping: one unit per step period, only while motion allowed
  wire step_tick         = (step_cnt_r == 8'(STEP_CYC - 1));
  wire in_motion         = (state_r != S_IDLE);
  wire may_step          = in_motion && ready && step_tick;
  wire paused            = in_motion && !ready;
  wire [PW-1:0] target   = (state_r == S_HOMING) ? POS_RST : point_r[tgt_idx_r];
  wire at_target         = (pos_r == target);
  wire cancel            = clear_edge && paused && !pause_hi;

  // position update toward the target
  always_comb begin
    pos_nxt = pos_r;
    if (may_step && !at_target) begin
      if (pos_r < target) begin
        pos_nxt = pos_r + 16'h0001;
      end else begin
        pos_nxt = pos_r - 16'h0001;
      end
    end
  end

  // axis sequencer
  always_comb begin
    state_nxt    = state_r;
    tgt_idx_nxt  = tgt_idx_r;
    go_after_nxt = go_after_r;
    homed_nxt    = homed_r;
    done_nxt     = done_r;
    case (state_r)
      S_HOMING: begin
        if (may_step && at_target) begin
          homed_nxt = 1'b1;
          state_nxt = go_after_r ? S_MOVING : S_IDLE;
        end
      end
      S_MOVING: begin
        if (may_step && at_target) begin
          done_nxt[tgt_idx_r] = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    if (home_cmd && !alarm_r && state_r == S_IDLE) begin
      state_nxt    = S_HOMING;
      go_after_nxt = 1'b0;
      done_nxt     = 4'h0;
    end
    if (move_req) begin
      tgt_idx_nxt  = move_idx;
      done_nxt     = 4'h0;
      go_after_nxt = 1'b1;
      state_nxt    = homed_r ? S_MOVING : S_HOMING;
    end
    if (cancel || alarm_r) begin
      state_nxt    = S_IDLE;
      go_after_nxt = 1'b0;
    end
  end

  // alarm: raised by software or estop during motion; set beats clear
  always_comb begin
    alarm_nxt = alarm_r;
    if (clear_edge) begin
      alarm_nxt = 1'b0;
    end
    if (alarm_cmd || (in_motion && estop)) begin
      alarm_nxt = 1'b1;
    end
  end

  // register read mux
  always_comb begin
    rdata_nxt = '0;
    if (reg_req.addr == OFS_CTRL) begin
      rdata_nxt = {29'h0, ctrl_r};
    end else if (reg_req.addr == OFS_PATTERN) begin
      rdata_nxt = {29'h0, pattern_r};
    end else if (reg_req.addr == OFS_POINT0) begin
      rdata_nxt = {16'h0, point_r[0]};
    end else if (reg_req.addr == OFS_POINT1) begin
      rdata_nxt = {16'h0, point_r[1]};
    end else if (reg_req.addr == OFS_POINT2) begin
      rdata_nxt = {16'h0, point_r[2]};
    end else if (reg_req.addr == OFS_POINT3) begin
      rdata_nxt = {16'h0, point_r[3]};
    end else if (reg_req.addr == OFS_ZONE_LO) begin
      rdata_nxt = {16'h0, zone_lo_r};
    end else if (reg_req.addr == OFS_ZONE_HI) begin
      rdata_nxt = {16'h0, zone_hi_r};
    end else if (reg_req.addr == OFS_STATUS) begin
      rdata_nxt[ST_HOMED]          = homed_r;
      rdata_nxt[ST_ALARM]          = alarm_r;
      rdata_nxt[ST_MOVING]         = in_motion;
      rdata_nxt[ST_PAUSED]         = paused;
      rdata_nxt[ST_READY]          = ready;
      rdata_nxt[ST_DONE+3:ST_DONE] = done_r;
      rdata_nxt[ST_ZONE]           = window_flag_out;
    end else if (reg_req.addr == OFS_POSITION) begin
      rdata_nxt = {16'h0, pos_r};
    end
  end

  // stored points, one writable word each
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_point
      wire wr_point = reg_req.wr && (reg_req.addr == OFS_POINT0 + 8'(4 * gi));
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          point_r[gi] <= POINT_RST;
        end else if (wr_point) begin
          point_r[gi] <= reg_req.wdata[PW-1:0];
        end
      end
    end
  endgenerate

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= CTRL_RST;
      pattern_r <= PATTERN_RST;
      zone_lo_r <= ZONE_LO_RST;
      zone_hi_r <= ZONE_HI_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_req.wdata[2:0];
      if (wr_pattern) pattern_r <= reg_req.wdata[2:0];
      if (wr_zone_lo) zone_lo_r <= reg_req.wdata[PW-1:0];
      if (wr_zone_hi) zone_hi_r <= reg_req.wdata[PW-1:0];
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_req.rd ? rdata_nxt : '0;
    end
  end

  // step period divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_r <= 8'h00;
    end else begin
      step_cnt_r <= step_tick ? 8'h00 : step_cnt_r + 8'h01;
    end
  end

  // axis state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= S_IDLE;
      pos_r      <= POS_RST;
      tgt_idx_r  <= 2'd0;
      go_after_r <= 1'b0;
      homed_r    <= 1'b0;
      alarm_r    <= 1'b0;
      done_r     <= 4'h0;
      pin_prev_r <= PIN_IDLE;
    end else begin
      state_r    <= state_nxt;
      pos_r      <= pos_nxt;
      tgt_idx_r  <= tgt_idx_nxt;
      go_after_r <= go_after_nxt;
      homed_r    <= homed_nxt;
      alarm_r    <= alarm_nxt;
      done_r     <= done_nxt;
      pin_prev_r <= pin_lvl;
    end
  end

  // registered pin outputs, idle levels outside pattern five
  wire in_zone = homed_r && (pos_r >= zone_lo_r) && (pos_r <= zone_hi_r);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rear_end_done_out    <= 1'b0;
      front_end_done_out   <= 1'b0;
      mid_point_a_done_out <= 1'b0;
      mid_point_b_done_out <= 1'b0;
      window_flag_out      <= 1'b0;
      axis_ready_out       <= 1'b0;
      homing_done_out      <= 1'b0;
      fault_n_out          <= 1'b1;
      estop_state_n_out    <= 1'b1;
    end else begin
      rear_end_done_out    <= pat_on && done_nxt[0];
      front_end_done_out   <= pat_on && done_nxt[1];
      mid_point_a_done_out <= pat_on && done_nxt[2];
      mid_point_b_done_out <= pat_on && done_nxt[3];
      window_flag_out      <= pat_on && in_zone;
      axis_ready_out       <= ready;
      homing_done_out      <= pat_on && homed_r;
      fault_n_out          <= !(pat_on && alarm_r);
      estop_state_n_out    <= !(pat_on && relay_fitted && estop);
    end
  end
endmodule

// ===== test/plc_model.sv
`timescale 1ns/1ps
module plc_model #(
  parameter int unsigned HOLD = 12
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] pulse_req,
  input  wire logic       pause_req,
  output logic      [4:0] pins,
  output logic            pause_n
);
  logic [7:0] hold_r [5];
  // each strobe pin stays high well past the input filter, then drops low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++) begin
        hold_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        hold_r[i] <= pulse_req[i] ? 8'(HOLD) : hold_r[i] - 8'(hold_r[i] != '0);
      end
    end
  end
  // pins: 4 move strobes then alarm clear; pause line idles high
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pins[i] = hold_r[i] != '0;
    end
    pause_n = !pause_req;
  end
endmodule

// ===== test/four_point_io_chk.sv
`timescale 1ns/1ps
module four_point_io_chk
  import pio_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = 4
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire pio_pkg::reg_req_s reg_req,
  input wire logic              rear_end_move_in,
  input wire logic              front_end_move_in,
  input wire logic              mid_point_a_move_in,
  input wire logic              mid_point_b_move_in,
  input wire logic              pause_n_in,
  input wire logic              estop_req_in,
  input wire logic              rear_end_done_out,
  input wire logic              front_end_done_out,
  input wire logic              mid_point_a_done_out,
  input wire logic              mid_point_b_done_out,
  input wire logic              window_flag_out,
  input wire logic              axis_ready_out,
  input wire logic              homing_done_out,
  input wire logic              fault_n_out,
  input wire logic              estop_state_n_out
);
  localparam int unsigned LIM = DEBOUNCE_CYCLES + 8;
  logic [31:0] pause_lo_r, estop_hi_r, estop_lo_r, quiet_r;
  wire [3:0] done = {mid_point_b_done_out, mid_point_a_done_out, front_end_done_out, rear_end_done_out};
  wire       kick = rear_end_move_in | front_end_move_in | mid_point_a_move_in | mid_point_b_move_in;
  // how long pause has been low and estop high or low, and cycles since the last move strobe or register write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_lo_r <= '0;
      estop_hi_r <= '0;
      estop_lo_r <= '0;
      quiet_r    <= '0;
    end else begin
      pause_lo_r <= pause_n_in ? '0 : pause_lo_r + 1;
      estop_hi_r <= estop_req_in ? estop_hi_r + 1 : '0;
      estop_lo_r <= estop_req_in ? '0 : estop_lo_r + 1;
      quiet_r    <= (kick | reg_req.wr) ? '0 : quiet_r + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_done_one_hot: assert property ($onehot0(done)) else $error("two done outputs high");
  chk_ready_pause: assert property (pause_lo_r > LIM |-> !axis_ready_out) else $error("ready while paused");
  chk_ready_estop: assert property (estop_hi_r > LIM |-> !axis_ready_out) else $error("ready in estop");
  chk_estop_idle: assert property (estop_lo_r > LIM |-> estop_state_n_out) else $error("estop status low");
  chk_window_homed: assert property (window_flag_out |-> homing_done_out) else $error("window unhomed");
  chk_done_homed: assert property (|done |-> homing_done_out) else $error("done before homing");
  chk_homed_holds: assert property (homing_done_out && quiet_r > LIM && !reg_req.wr |=> homing_done_out)
    else $error("homing done dropped");
  chk_done_held: assert property (quiet_r > LIM && !reg_req.wr |-> !$fell(|done))
    else $error("done dropped without command");
  cover property ($rose(rear_end_done_out));
  cover property (window_flag_out);
  cover property (!fault_n_out);
  cover property (!estop_state_n_out);
endmodule
bind four_point_io four_point_io_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (.clk, .rst_n, .reg_req,
  .rear_end_move_in, .front_end_move_in, .mid_point_a_move_in, .mid_point_b_move_in, .pause_n_in, .estop_req_in,
  .rear_end_done_out, .front_end_done_out, .mid_point_a_done_out, .mid_point_b_done_out, .window_flag_out,
  .axis_ready_out, .homing_done_out, .fault_n_out, .estop_state_n_out);

// ===== test/four_point_parallel_io_tb.sv
`timescale 1ns/1ps
module four_point_parallel_io_tb;
  import pio_pkg::*;
  localparam int unsigned DEB = 4;
  logic          clk, rst_n, pause_req, estop, pause_n;
  reg_req_s      req;
  logic [DW-1:0] rdata, p1;
  logic [4:0]    pulse_req, pins;
  logic [8:0]    outs;
  logic [15:0]   pt [4] = '{16'h0002, 16'h0008, 16'h0004, 16'h0006};
  int            ord [4] = '{0, 2, 3, 1};
  int            n_errors, checks_done;
  plc_model #(.HOLD(DEB + 8)) u_plc (.clk, .rst_n, .pulse_req, .pause_req, .pins, .pause_n);
  four_point_io #(.DEBOUNCE_CYCLES(DEB)) u_dut (.clk, .rst_n, .reg_req(req), .reg_rdata(rdata),
    .rear_end_move_in(pins[0]), .front_end_move_in(pins[1]), .mid_point_a_move_in(pins[2]),
    .mid_point_b_move_in(pins[3]), .pause_n_in(pause_n), .alarm_clear_in(pins[4]), .estop_req_in(estop),
    .rear_end_done_out(outs[0]), .front_end_done_out(outs[1]), .mid_point_a_done_out(outs[2]),
    .mid_point_b_done_out(outs[3]), .window_flag_out(outs[4]), .axis_ready_out(outs[5]),
    .homing_done_out(outs[6]), .fault_n_out(outs[7]), .estop_state_n_out(outs[8]));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk("register", exp, d);
  endtask
  // one strobe to the controller model, then wait for it to act
  task automatic kick(input int k, input int n);
    @(posedge clk);
    pulse_req <= 5'(1) << k;
    @(posedge clk);
    pulse_req <= '0;
    tick(n);
  endtask
  task automatic wait_done(input int k);
    for (int i = 0; i < 400 && outs[k] !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #2_000_000;
    n_errors++;
    tally_and_finish();
  end
  // test sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    pulse_req = '0;
    pause_req = 1'b0;
    estop = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    chk("reset outputs", 9'h180, outs);
    rc(OFS_PATTERN, 32'h0);
    rc(OFS_ZONE_HI, 32'hffff);
    rc(8'h30, 32'h0);
    wr(OFS_PATTERN, 32'h5);
    wr(OFS_CTRL, 32'h7);
    for (int k = 0; k < 4; k++) wr(OFS_POINT0 + 8'(4 * k), 32'(pt[k]));
    wr(OFS_ZONE_LO, 32'h3);
    wr(OFS_ZONE_HI, 32'h5);
    tick(DEB + 8);
    chk("ready unhomed", 9'h1a0, outs);
    foreach (ord[j]) begin
      kick(ord[j], 1);
      wait_done(ord[j]);
      chk("arrival", 9'h1e0 | 9'(pt[ord[j]] == 16'h4) << 4 | 9'(1) << ord[j], outs);
      rc(OFS_POSITION, 32'(pt[ord[j]]));
    end
    kick(0, DEB + 25);
    @(posedge clk) pause_req <= 1'b1;
    tick(DEB + 8);
    rd(OFS_POSITION, p1);
    tick(60);
    rc(OFS_POSITION, p1);
    chk("paused", 9'h1c0, outs & 9'h1ef);
    @(posedge clk) pause_req <= 1'b0;
    wait_done(0);
    chk("resumed", 9'h1e1, outs);
    kick(1, DEB + 25);
    @(posedge clk) pause_req <= 1'b1;
    kick(4, DEB + 16);
    rd(OFS_POSITION, p1);
    @(posedge clk) pause_req <= 1'b0;
    tick(200);
    rc(OFS_POSITION, p1);
    chk("cancelled", 9'h1e0, outs & 9'h1ef);
    wr(OFS_CTRL, 32'h17);
    tick(4);
    chk("alarm", 9'h160, outs & 9'h1ef);
    kick(2, DEB + 40);
    rc(OFS_POSITION, p1);
    kick(4, DEB + 8);
    chk("alarm cleared", 9'h1e0, outs & 9'h1ef);
    // software home command returns the axis to position zero
    wr(OFS_CTRL, 32'hf);
    tick(120);
    rc(OFS_POSITION, 32'h0);
    rc(OFS_STATUS, 32'h11);
    @(posedge clk) estop <= 1'b1;
    tick(DEB + 8);
    chk("estop", 9'h0c0, outs & 9'h1ef);
    wr(OFS_CTRL, 32'h3);
    tick(4);
    chk("no relay", 9'h1c0, outs & 9'h1ef);
    estop <= 1'b0;
    wr(OFS_CTRL, 32'h7);
    wr(OFS_PATTERN, 32'h4);
    tick(4);
    chk("other pattern", 9'h180, outs);
    kick(3, DEB + 40);
    rc(OFS_POSITION, 32'h0);
    tally_and_finish();
  end
endmodule
